// File: hw/fb_slave_handler.sv
`timescale 1ns/1ps
`default_nettype none

// Operation
// (RULE1) Execute only codes 03h, 06h, 08h, 10h.
// (RULE2) Read returns up to sixteen consecutive registers.
// (RULE3) Multiple reads go in ascending address order.
// (RULE4) Master reads both halves together.
// (RULE5) Read query: address, code, start, count.
// (RULE6) Read answer: byte count, values high first.
// (RULE7) Frames end with check, low byte first.
// (RULE8) Single write stores value at given address.
// (RULE9) Single write answer echoes the query.
// (RULE10) Master uses 10h for 32-bit values.
// (RULE11) Diagnosis sub 00h echoes data unchanged.
// (RULE12) Multiple write stores up to sixteen registers.
// (RULE13) Multiple writes commit in ascending order.
// (RULE14) Master writes both halves together.
// (RULE15) Rejected values may follow stored ones.
// (RULE16) Exception: address, code plus 80h, code.
// (RULE17) Code 01h for bad function or sub.
// (RULE18) Code 02h for address past 1FFFh; 03h and 10h ranges ending at 1FFFh also get 02h here.
// (RULE19) Code 03h for bad count or bytes.
// (RULE20) Answer only good, addressed, checked frames.
// (RULE21) One query at a time.
module fb_slave_handler (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic [7:0] slave_addr,
	input wire fb_slave_pkg::rx_byte_t rx_i,
	output logic rx_ready,
	output fb_slave_pkg::tx_byte_t tx_o,
	input wire logic tx_ready,
	output fb_slave_pkg::reg_req_t reg_o,
	input wire fb_slave_pkg::reg_resp_t reg_i
);
	import fb_slave_pkg::*;
	default clocking sys_cb @(posedge sys_clk); endclocking // Clock of every check below.
	default disable iff (!rstn); // Checks sleep while reset is held.

	// ==========================================================
	// Check value update, one byte, reflected generator.
	function automatic logic [15:0] crc_upd(input logic [15:0] crc, input logic [7:0] b);
		logic [15:0] c;
		c = crc ^ {8'h00, b};
		for (int k = 0; k < 8; k++) begin
			c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
		end
		return c;
	endfunction : crc_upd

	// ==========================================================
	// State.
	state_t state_ff, nxt_state; // Sequencer state.
	logic [7:0] buf_ff [RX_DEPTH]; // Received query bytes.
	logic [7:0] nxt_buf [RX_DEPTH];
	logic [15:0] rd_ff [16]; // Values fetched for a read answer.
	logic [15:0] nxt_rd [16];
	logic [6:0] len_ff, nxt_len; // Bytes received so far.
	logic ovf_ff, nxt_ovf; // Query longer than the buffer.
	logic [15:0] crc_ff, nxt_crc; // Running check, shared by receive and send.
	logic [7:0] exc_ff, nxt_exc; // Pending exception code.
	logic [4:0] cnt_ff, nxt_cnt; // Registers to access.
	logic [3:0] ri_ff, nxt_ri; // Register being accessed.
	logic [5:0] tx_cnt_ff, nxt_tx_cnt; // Bytes loaded for sending.
	tx_byte_t tx_ff, nxt_tx;
	reg_req_t reg_ff, nxt_reg;
	logic rx_ready_ff, nxt_rx_ready;

	// ==========================================================
	// Query fields.
	logic [7:0] fc;
	logic [15:0] a16;
	logic [15:0] n16;
	logic [7:0] bc;
	logic [16:0] a_end;
	logic frame_ok;
	logic [7:0] dec_exc;
	logic [5:0] tx_len;
	logic [7:0] pay_byte;
	logic [5:0] wr_idx;
	logic [5:0] rd_off;

	assign fc = buf_ff[1];
	assign a16 = {buf_ff[2], buf_ff[3]};
	assign n16 = {buf_ff[4], buf_ff[5]};
	assign bc = buf_ff[6];
	assign a_end = {1'b0, a16} + {1'b0, n16};
	assign wr_idx = WR_DATA0 + {1'b0, ri_ff, 1'b0};
	assign rd_off = tx_cnt_ff - RD_HDR;

	// A frame is kept only if it is whole, addressed here and checks to zero.
	assign frame_ok = !ovf_ff && (len_ff >= MIN_FRAME) && (crc_ff == 16'h0000)
		&& (buf_ff[0] == slave_addr); // RULE20

	// Validation, in the order function, count and length, then address.
	// Count comes before address so a huge count is reported as bad data.
	always_comb begin
		dec_exc = EXC_NONE;
		if (fc != FC_READ && fc != FC_WRITE1 && fc != FC_DIAG && fc != FC_WRITEN) begin
			dec_exc = EXC_FUNC; // RULE1 RULE17
		end else if (fc == FC_DIAG) begin
			if (a16 != DIAG_SUB) begin
				dec_exc = EXC_FUNC; // RULE11 RULE17
			end else if (len_ff != FIXED_LEN) begin
				dec_exc = EXC_DATA;
			end
		end else if (fc == FC_WRITE1) begin
			if (len_ff != FIXED_LEN) begin
				dec_exc = EXC_DATA;
			end else if (a16 > ADDR_MAX) begin
				dec_exc = EXC_ADDR; // RULE18
			end
		end else begin
			if (n16 == 16'h0000 || n16 > {11'h000, MAX_REGS}) begin
				dec_exc = EXC_DATA; // RULE2 RULE12 RULE19
			end else if (fc == FC_WRITEN && ({bc, 1'b0} != {n16[7:0], 1'b0} << 1
				|| len_ff != HDR10_LEN + bc[6:0])) begin
				dec_exc = EXC_DATA; // RULE19
			end else if (fc == FC_READ && len_ff != FIXED_LEN) begin
				dec_exc = EXC_DATA;
			end else if (a_end >= ADDR_LIMIT) begin
				dec_exc = EXC_ADDR; // RULE18
			end
		end
	end

	// ==========================================================
	// Answer bytes by position, before the two check bytes.
	assign tx_len = (exc_ff != EXC_NONE) ? EXC_LEN :
		(fc == FC_READ) ? (RD_HDR + {cnt_ff, 1'b0}) : ECHO_LEN;

	always_comb begin
		pay_byte = buf_ff[tx_cnt_ff];
		if (exc_ff != EXC_NONE) begin
			if (tx_cnt_ff == 6'h01) begin
				pay_byte = fc | EXC_FLAG; // RULE16
			end else if (tx_cnt_ff == 6'h02) begin
				pay_byte = exc_ff; // RULE16
			end
		end else if (fc == FC_READ && tx_cnt_ff == 6'h02) begin
			pay_byte = {2'b00, cnt_ff, 1'b0}; // RULE6
		end else if (fc == FC_READ && tx_cnt_ff >= RD_HDR) begin
			pay_byte = rd_off[0] ? rd_ff[rd_off[4:1]][7:0] : rd_ff[rd_off[4:1]][15:8]; // RULE6
		end
	end

	// ==========================================================
	// Next-state logic for the whole sequencer.
	always_comb begin
		nxt_state = state_ff;
		nxt_buf = buf_ff;
		nxt_rd = rd_ff;
		nxt_len = len_ff;
		nxt_ovf = ovf_ff;
		nxt_crc = crc_ff;
		nxt_exc = exc_ff;
		nxt_cnt = cnt_ff;
		nxt_ri = ri_ff;
		nxt_tx_cnt = tx_cnt_ff;
		nxt_tx = tx_ff;
		nxt_reg = reg_ff;
		case (state_ff)
			S_RX: begin
				// Bytes are only taken here, so a query never overlaps an answer.
				if (rx_i.valid && rx_ready_ff) begin
					if (len_ff < RX_DEPTH_W) begin
						nxt_buf[len_ff[5:0]] = rx_i.data;
						nxt_len = len_ff + 7'h01;
						nxt_crc = crc_upd(crc_ff, rx_i.data); // RULE7
					end else begin
						nxt_ovf = 1'b1;
					end
				end
				if (rx_i.last && rx_ready_ff) begin
					if (frame_ok) begin
						nxt_state = S_DEC;
					end else begin
						// Foreign or damaged frames are dropped without a word.
						nxt_len = 7'h00; // RULE20
						nxt_ovf = 1'b0;
						nxt_crc = CRC_INIT;
					end
				end
			end
			S_DEC: begin
				nxt_exc = dec_exc;
				nxt_cnt = (fc == FC_WRITE1) ? 5'h01 : n16[4:0];
				nxt_ri = 4'h0;
				nxt_crc = CRC_INIT;
				nxt_tx_cnt = 6'h00;
				nxt_state = (dec_exc == EXC_NONE && fc != FC_DIAG) ? S_EXEC : S_TX;
			end
			S_EXEC: begin
				if (!reg_ff.req) begin
					// Each access starts one register above the last.
					nxt_reg.req = 1'b1;
					nxt_reg.we = (fc != FC_READ); // RULE8 RULE12
					nxt_reg.addr = a16 + {12'h000, ri_ff}; // RULE3 RULE13
					nxt_reg.wdata = (fc == FC_WRITE1) ? n16 :
						{buf_ff[wr_idx], buf_ff[wr_idx + 6'h01]};
				end else if (reg_i.ack) begin
					nxt_reg.req = 1'b0;
					if (!reg_ff.we) begin
						nxt_rd[ri_ff] = reg_i.rdata; // RULE2
					end
					// A refused value does not stop later writes of the query.
					if (reg_i.err) begin
						nxt_exc = EXC_SLAVE; // RULE15
					end
					if ({1'b0, ri_ff} + 5'h01 == cnt_ff) begin
						nxt_state = S_TX;
					end else begin
						nxt_ri = ri_ff + 4'h1;
					end
				end
			end
			S_TX: begin
				if (!tx_ff.valid || tx_ready) begin
					if (tx_ff.valid && tx_ff.last) begin
						nxt_tx.valid = 1'b0;
						nxt_tx.last = 1'b0;
						nxt_state = S_RX; // RULE21
						nxt_len = 7'h00;
						nxt_ovf = 1'b0;
						nxt_crc = CRC_INIT;
					end else begin
						nxt_tx.valid = 1'b1;
						nxt_tx_cnt = tx_cnt_ff + 6'h01;
						if (tx_cnt_ff < tx_len) begin
							nxt_tx.data = pay_byte; // RULE9 RULE11
							nxt_tx.last = 1'b0;
							nxt_crc = crc_upd(crc_ff, pay_byte);
						end else if (tx_cnt_ff == tx_len) begin
							nxt_tx.data = crc_ff[7:0]; // RULE7
							nxt_tx.last = 1'b0;
						end else begin
							nxt_tx.data = crc_ff[15:8]; // RULE7
							nxt_tx.last = 1'b1;
						end
					end
				end
			end
			default: begin
				nxt_state = S_RX;
			end
		endcase
		nxt_rx_ready = (nxt_state == S_RX); // RULE21
	end

	// ==========================================================
	// Registers. Buffers keep no reset; they are written before they are read.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state_ff <= S_RX;
			len_ff <= 7'h00;
			ovf_ff <= 1'b0;
			crc_ff <= CRC_INIT;
			exc_ff <= EXC_NONE;
			cnt_ff <= 5'h00;
			ri_ff <= 4'h0;
			tx_cnt_ff <= 6'h00;
			tx_ff <= '0;
			reg_ff <= '0;
			rx_ready_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			len_ff <= nxt_len;
			ovf_ff <= nxt_ovf;
			crc_ff <= nxt_crc;
			exc_ff <= nxt_exc;
			cnt_ff <= nxt_cnt;
			ri_ff <= nxt_ri;
			tx_cnt_ff <= nxt_tx_cnt;
			tx_ff <= nxt_tx;
			reg_ff <= nxt_reg;
			rx_ready_ff <= nxt_rx_ready;
		end
	end

	always_ff @(posedge sys_clk) begin
		buf_ff <= nxt_buf;
		rd_ff <= nxt_rd;
	end

	assign tx_o = tx_ff;
	assign reg_o = reg_ff;
	assign rx_ready = rx_ready_ff;

	// ==========================================================
	// Checks.
	property p_fc_unsup;
		(state_ff == S_DEC && fc != FC_READ && fc != FC_WRITE1 && fc != FC_DIAG
			&& fc != FC_WRITEN) |=> (exc_ff == EXC_FUNC && state_ff == S_TX);
	endproperty
	a_fc_unsup: assert property (p_fc_unsup) else $error("unsupported code not refused"); // RULE1
	property p_cnt_max;
		(state_ff == S_EXEC) |-> (cnt_ff != 5'h00 && cnt_ff <= MAX_REGS);
	endproperty
	a_cnt_max: assert property (p_cnt_max) else $error("access count out of range"); // RULE2
	property p_ascend;
		($rose(reg_o.req) && ri_ff != 4'h0) |-> (reg_o.addr == $past(reg_o.addr) + 16'h0001);
	endproperty
	a_ascend: assert property (p_ascend) else $error("register order not ascending"); // RULE3
	// The byte count is held against the count field of the query itself.
	property p_rd_count;
		(tx_o.valid && exc_ff == EXC_NONE && fc == FC_READ && tx_cnt_ff == 6'h03)
			|-> (tx_o.data == {n16[6:0], 1'b0});
	endproperty
	a_rd_count: assert property (p_rd_count) else $error("byte count not twice count"); // RULE6
	property p_exc_fc;
		(tx_o.valid && exc_ff != EXC_NONE && tx_cnt_ff == 6'h02) |-> (tx_o.data == (fc | EXC_FLAG));
	endproperty
	a_exc_fc: assert property (p_exc_fc) else $error("exception code byte wrong"); // RULE16
	property p_addr_bad;
		(state_ff == S_DEC && fc == FC_READ && len_ff == FIXED_LEN && n16 == 16'h0001
			&& a16 > ADDR_MAX) |=> (exc_ff == EXC_ADDR);
	endproperty
	a_addr_bad: assert property (p_addr_bad) else $error("bad address not refused"); // RULE18
	property p_cnt_zero;
		(state_ff == S_DEC && (fc == FC_READ || fc == FC_WRITEN) && n16 == 16'h0000)
			|=> (exc_ff == EXC_DATA ##1 state_ff == S_TX);
	endproperty
	a_cnt_zero: assert property (p_cnt_zero) else $error("zero count not refused"); // RULE19
	property p_silent;
		(state_ff == S_RX && rx_i.last && !frame_ok) |=> (state_ff == S_RX && !tx_o.valid)[*2];
	endproperty
	a_silent: assert property (p_silent) else $error("answer to bad frame"); // RULE20
	property p_one_query;
		(tx_o.valid && tx_o.last && tx_ready) |=> (state_ff == S_RX && rx_ready && !tx_o.valid);
	endproperty
	a_one_query: assert property (p_one_query) else $error("receiver not reopened"); // RULE21
	property p_partial;
		(state_ff == S_EXEC && reg_o.req && reg_o.we && reg_i.ack && reg_i.err)
			|=> (exc_ff == EXC_SLAVE);
	endproperty
	a_partial: assert property (p_partial) else $error("refused write not flagged"); // RULE15

endmodule : fb_slave_handler

`default_nettype wire

// File: hw/fb_slave_pkg.sv
package fb_slave_pkg;

	// ==========================================================
	// Function codes and exception answers.
	localparam logic [7:0] FC_READ = 8'h03; // Read of successive holding registers.
	localparam logic [7:0] FC_WRITE1 = 8'h06; // Write of one holding register.
	localparam logic [7:0] FC_DIAG = 8'h08; // Loopback diagnosis.
	localparam logic [7:0] FC_WRITEN = 8'h10; // Write of successive holding registers.
	localparam logic [7:0] EXC_FLAG = 8'h80; // Added to the function code in an exception.
	localparam logic [7:0] EXC_NONE = 8'h00; // No exception pending.
	localparam logic [7:0] EXC_FUNC = 8'h01; // Unsupported function or sub-function.
	localparam logic [7:0] EXC_ADDR = 8'h02; // Address outside the register space.
	localparam logic [7:0] EXC_DATA = 8'h03; // Bad count, byte count or frame length.
	localparam logic [7:0] EXC_SLAVE = 8'h04; // Register port refused a value.
	localparam logic [15:0] DIAG_SUB = 16'h0000; // Only loopback sub-function.

	// ==========================================================
	// Frame layout and limits.
	localparam logic [4:0] MAX_REGS = 5'h10; // At most sixteen registers a query.
	localparam logic [16:0] ADDR_LIMIT = 17'h02000; // First address past the space.
	localparam logic [15:0] ADDR_MAX = 16'h1fff; // Last valid register address.
	localparam int RX_DEPTH = 64; // Query buffer depth in bytes.
	localparam logic [6:0] RX_DEPTH_W = 7'h40; // Same depth at counter width.
	localparam logic [6:0] MIN_FRAME = 7'h04; // Address, code and two check bytes.
	localparam logic [6:0] FIXED_LEN = 7'h08; // Length of 03h, 06h and 08h queries.
	localparam logic [6:0] HDR10_LEN = 7'h09; // 10h header and check bytes.
	localparam logic [5:0] RD_HDR = 6'h03; // Address, code and byte count.
	localparam logic [5:0] EXC_LEN = 6'h03; // Exception payload length.
	localparam logic [5:0] ECHO_LEN = 6'h06; // Echo payload length.
	localparam logic [5:0] WR_DATA0 = 6'h07; // First data byte of a 10h query.

	// ==========================================================
	// Check value.
	localparam logic [15:0] CRC_INIT = 16'hffff; // Check register start value.
	localparam logic [15:0] CRC_POLY = 16'ha001; // Reflected generator.

	// ==========================================================
	// Types.
	typedef enum logic [1:0] {
		S_RX = 2'b00,
		S_DEC = 2'b01,
		S_EXEC = 2'b10,
		S_TX = 2'b11
	} state_t;

	// One received byte or the end of a frame from the framing logic.
	typedef struct packed {
		logic valid;
		logic last;
		logic [7:0] data;
	} rx_byte_t;

	// One byte offered to the transmitter.
	typedef struct packed {
		logic valid;
		logic last;
		logic [7:0] data;
	} tx_byte_t;

	// Request towards the holding register store.
	typedef struct packed {
		logic req;
		logic we;
		logic [15:0] addr;
		logic [15:0] wdata;
	} reg_req_t;

	// Answer of the holding register store.
	typedef struct packed {
		logic ack;
		logic err;
		logic [15:0] rdata;
	} reg_resp_t;

endpackage : fb_slave_pkg

// File: tb/fb_reg_store.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Register store model on the far side of the register port.
module fb_reg_store (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic slow,
	input wire logic [15:0] bad_addr,
	input wire fb_slave_pkg::reg_req_t req,
	output var fb_slave_pkg::reg_resp_t resp
);
	import fb_slave_pkg::*;
	logic [15:0] mem [0:255]; // Indexed by the low address byte.
	logic [1:0] wait_ff; // Stall cycles spent on this access.
	// Unwritten places read a pattern made from their index.
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i] <= {8'h5a, 8'(i)};
		end
	end
	// Read data toggles between answers, so late sampling is caught.
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			resp <= '0;
			wait_ff <= 2'h0;
		end else begin
			resp.ack <= 1'b0;
			resp.err <= 1'b0;
			resp.rdata <= ~resp.rdata;
			if (req.req && !resp.ack) begin
				wait_ff <= wait_ff + 2'h1;
				if (!slow || wait_ff == 2'h3) begin
					wait_ff <= 2'h0;
					resp.ack <= 1'b1;
					resp.rdata <= mem[req.addr[7:0]];
					if (req.we && req.addr == bad_addr) begin
						resp.err <= 1'b1;
					end else if (req.we) begin
						mem[req.addr[7:0]] <= req.wdata;
					end
				end
			end
		end
	end
endmodule : fb_reg_store
`default_nettype wire

// File: tb/fb_slave_handler_tb.sv
`timescale 1ns/1ps
`default_nettype none
module fb_slave_handler_tb;
	import fb_slave_pkg::*;
	// ==========================================================
	// Stimulus and observed signals.
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] slave_addr = 8'h01; // Own station address.
	rx_byte_t rx_i = '0;
	logic rx_ready;
	tx_byte_t tx_o;
	logic tx_ready = 1'b0;
	reg_req_t reg_o;
	reg_resp_t reg_i;
	logic slow = 1'b0; // Makes the store stall before each answer.
	logic [15:0] bad_addr = 16'hffff; // Address the store refuses.
	int mismatches = 0;
	int samples_checked = 0;
	logic [7:0] q[$];
	logic [7:0] e[$];
	always #10 sys_clk = ~sys_clk;
	fb_slave_handler dut (.sys_clk(sys_clk), .rstn(rstn), .slave_addr(slave_addr),
		.rx_i(rx_i), .rx_ready(rx_ready), .tx_o(tx_o), .tx_ready(tx_ready),
		.reg_o(reg_o), .reg_i(reg_i));
	fb_reg_store store (.sys_clk(sys_clk), .rstn(rstn), .slow(slow),
		.bad_addr(bad_addr), .req(reg_o), .resp(reg_i));
	// ==========================================================
	// Reporting.
	task automatic conclude();
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : conclude
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task automatic stall(input string name);
		mismatches++;
		$display("[FAIL] %s wait expected done seen hang", name);
		conclude();
	endtask : stall
	// ==========================================================
	// Frame helpers; inputs change 1 ns after the rising edge.
	task automatic tick();
		@(posedge sys_clk);
		#1;
	endtask : tick
	function automatic logic [15:0] crc(input logic [7:0] b[$]);
		logic [15:0] c;
		c = CRC_INIT;
		foreach (b[i]) begin
			c = c ^ {8'h00, b[i]};
			for (int k = 0; k < 8; k++) begin
				c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
			end
		end
		return c;
	endfunction : crc
	task automatic seal(inout logic [7:0] b[$]);
		logic [15:0] c;
		c = crc(b);
		b.push_back(c[7:0]);
		b.push_back(c[15:8]);
	endtask : seal
	// Bytes go back to back; the end mark follows one idle cycle later.
	task automatic send(input logic [7:0] b[$]);
		int n;
		n = 0;
		while (rx_ready !== 1'b1) begin
			tick();
			n++;
			if (n > 500) stall("rx_ready");
		end
		foreach (b[i]) begin
			rx_i.valid = 1'b1;
			rx_i.data = b[i];
			tick();
		end
		rx_i = '0;
		tick();
		rx_i.last = 1'b1;
		tick();
		rx_i.last = 1'b0;
	endtask : send
	// Sends a query and compares the whole answer while the sink stalls.
	task automatic xfer(input string name, input logic [7:0] qb[$], input logic [7:0] eb[$]);
		logic [7:0] got[$];
		int n;
		seal(qb);
		seal(eb);
		send(qb);
		tick();
		chk("ready while busy", 16'h0, {15'h0, rx_ready});
		n = 0;
		while (1) begin
			@(negedge sys_clk);
			if (tx_o.valid === 1'b1 && tx_ready === 1'b1) begin
				got.push_back(tx_o.data);
				if (tx_o.last === 1'b1) break;
			end
			tick();
			tx_ready = (n % 3 != 0);
			n++;
			if (n > 900) stall(name);
		end
		tick();
		tx_ready = 1'b0;
		chk({name, " length"}, 16'(eb.size()), 16'(got.size()));
		foreach (eb[i]) begin
			chk(name, {8'h0, eb[i]}, (i < got.size()) ? {8'h0, got[i]} : 16'hxxxx);
		end
		$display("test %s done", name);
	endtask : xfer
	// ==========================================================
	// Scenarios.
	task automatic t_read();
		slow = 1'b1;
		q = {8'h01, FC_READ, 8'h1f, 8'hef, 8'h00, 8'h10};
		e = {8'h01, FC_READ, 8'h20};
		for (int i = 0; i < 16; i++) begin
			e.push_back(8'h5a);
			e.push_back(8'hef + 8'(i));
		end
		xfer("read16", q, e);
		slow = 1'b0;
	endtask : t_read
	task automatic t_write();
		q = {8'h01, FC_WRITE1, 8'h02, 8'h4b, 8'h00, 8'h50};
		xfer("write1", q, q);
		chk("reg 024b", 16'h0050, store.mem[8'h4b]);
		q = {8'h01, FC_DIAG, 8'h00, 8'h00, 8'h12, 8'h34};
		xfer("diag", q, q);
		q = {8'h01, FC_WRITEN, 8'h06, 8'h04, 8'h00, 8'h02, 8'h04, 8'h27, 8'h10, 8'h4e, 8'h20};
		e = {8'h01, FC_WRITEN, 8'h06, 8'h04, 8'h00, 8'h02};
		xfer("writen", q, e);
		chk("reg 0604", 16'h2710, store.mem[8'h04]);
		chk("reg 0605", 16'h4e20, store.mem[8'h05]);
	endtask : t_write
	// Refused first value: exception, yet the second value is kept.
	task automatic t_err();
		bad_addr = 16'h0030;
		q = {8'h01, FC_WRITEN, 8'h00, 8'h30, 8'h00, 8'h02, 8'h04, 8'h00, 8'h11, 8'h00, 8'h22};
		e = {8'h01, 8'h90, EXC_SLAVE};
		xfer("refused", q, e);
		chk("reg 0031", 16'h0022, store.mem[8'h31]);
		bad_addr = 16'hffff;
	endtask : t_err
	task automatic t_exc();
		q = {8'h01, 8'h05, 8'h00, 8'h00, 8'h00, 8'h01};
		xfer("bad code", q, {8'h01, 8'h85, EXC_FUNC});
		q = {8'h01, FC_DIAG, 8'h00, 8'h01, 8'h12, 8'h34};
		xfer("bad sub", q, {8'h01, 8'h88, EXC_FUNC});
		q = {8'h01, FC_READ, 8'h1f, 8'hf0, 8'h00, 8'h10};
		xfer("read end", q, {8'h01, 8'h83, EXC_ADDR});
		q = {8'h01, FC_WRITE1, 8'h20, 8'h00, 8'h00, 8'h01};
		xfer("write addr", q, {8'h01, 8'h86, EXC_ADDR});
		q = {8'h01, FC_READ, 8'h00, 8'h00, 8'h00, 8'h00};
		xfer("count 0", q, {8'h01, 8'h83, EXC_DATA});
		q = {8'h01, FC_WRITEN, 8'h00, 8'h00, 8'h00, 8'h11, 8'h22};
		xfer("count 17", q, {8'h01, 8'h90, EXC_DATA});
		q = {8'h01, FC_WRITEN, 8'h00, 8'h00, 8'h00, 8'h01, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00};
		xfer("bytes", q, {8'h01, 8'h90, EXC_DATA});
		q = {8'h01, FC_READ, 8'h20, 8'h00, 8'h00, 8'h01};
		xfer("read addr", q, {8'h01, 8'h83, EXC_ADDR});
		q = {8'h01, FC_READ, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
		xfer("read length", q, {8'h01, 8'h83, EXC_DATA});
	endtask : t_exc
	// Foreign address, broken check value and over-long frame get no answer.
	task automatic t_silent();
		int seen;
		for (int v = 0; v < 3; v++) begin
			q = {(v == 0) ? 8'h07 : 8'h01, FC_DIAG, 8'h00, 8'h00, 8'h12, 8'h34};
			// The third frame fills the buffer with a sound check, then one byte spills over.
			repeat ((v == 2) ? 56 : 0) q.push_back(8'h00);
			seal(q);
			if (v == 2) q.push_back(8'h00);
			q[7] = q[7] ^ 8'(v == 1);
			send(q);
			tx_ready = 1'b1;
			seen = 0;
			repeat (40) begin
				tick();
				seen += (tx_o.valid !== 1'b0);
			end
			tx_ready = 1'b0;
			chk("silent frames", 16'h0, 16'(seen));
			chk("still ready", 16'h1, {15'h0, rx_ready});
		end
		$display("test silent done");
	endtask : t_silent
	// ==========================================================
	// Main sequence.
	initial begin
		repeat (6) @(posedge sys_clk);
		#1;
		rstn = 1'b1;
		t_read();
		t_write();
		t_err();
		t_exc();
		t_silent();
		conclude();
	end
endmodule : fb_slave_handler_tb
`default_nettype wire
